// file: ext_mode_decode.sv
// Purpose: command decode and extended mode registers of the memory device
// Assumes: control pins come from outside and pass two flip-flops
// Notes: latency outputs are cycle counts; output enables high to drive
`timescale 1ns/1ns
`include "ext_mode_cfg.svh"

// Behaviour
// - Loop enable follows bit zero of extended register one on mode load.
// - Self refresh entry disables the loop; exit re-enables and resets it.
// - Drive strength bit zero gives full drive, one gives reduced drive.
// - Complement strobe driven as inverse unless complement disable bit set.
// - Read strobe complement on only if read strobe enabled and complement allowed.
// - Output disable bit turns off all data and strobe outputs.
// - Termination value chosen from both select bits; both bits set select the 50 setting.
// - Termination control acts only if enabled and not in self refresh.
// - Posted latency 0 to 6 taken from bits three to five.
// - Read or write held for the posted latency before internal issue.
// - Read latency is posted plus column; write latency is one less.
// - Extended registers keep contents until reloaded; register three reserved.
// - Commands decoded from five control pins at rising clock edge.
// - Strobe encodings map to load, refresh, precharge, activate, write, read, nop.
// - Line ten selects all banks on precharge, auto precharge on column commands.
// - Bank inputs on mode load choose which mode register is written.
// - Self refresh entry on clock enable fall with refresh; exit on rise.
// - Command decode ignores the termination control input.
module ext_mode_decode
   import ext_mode_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Command pins
   input wire logic chip_select_n,
   input wire logic row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic write_enable_n,
   input wire logic clock_enable,
   input wire logic [`BANK_W-1:0] bank_addr,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic termination_control,
   // Column latency from base mode register
   input wire logic [2:0] column_latency,
   // Output and strobe controls
   output logic loop_enable,
   output logic loop_reset,
   output logic loop_locked,
   output logic drive_reduced,
   output logic strobe_oe,
   output logic strobe_complement_oe,
   output logic read_strobe_oe,
   output logic read_strobe_complement_oe,
   output logic data_oe_allow,
   // Termination
   output term_sel_t termination_resistance,
   output logic termination_on,
   // Latencies
   output logic [2:0] posted_latency,
   output logic [3:0] read_latency,
   output logic [3:0] write_latency,
   // Internal command stream
   output cmd_t last_cmd,
   output logic self_refresh,
   output logic power_down,
   output logic precharge_issue,
   output logic precharge_all,
   output logic [`BANK_W-1:0] precharge_bank,
   output logic activate_issue,
   output col_cmd_t column_issue,
   output logic [`ADDR_W-1:0] ext_two_value
);
   cmd_pins_t pins_s1_q, pins_s2_q;
   logic [`BANK_W-1:0] bank_s1_q, bank_s2_q;
   logic [`ADDR_W-1:0] addr_s1_q, addr_s2_q;
   logic term_s1_q, term_s2_q;
   logic cke_prev_q;
   logic [`ADDR_W-1:0] ext_one_q, ext_two_q, ext_three_q;
   logic self_q, pdown_q;
   logic [7:0] lock_cnt_q;
   logic reset_pulse_q;
   cmd_t cmd;
   col_cmd_t col_in, col_out;
   cmd_pins_t pins_raw;

   function automatic logic bit_of(input logic [`ADDR_W-1:0] v, input int pos);
      bit_of = v[pos];
   endfunction

   assign pins_raw = '{chip_select_n, row_strobe_n, col_strobe_n, write_enable_n, clock_enable};

   // Two-stage capture of every pin
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_s1_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
         pins_s2_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
         bank_s1_q <= '0;
         bank_s2_q <= '0;
         addr_s1_q <= '0;
         addr_s2_q <= '0;
         term_s1_q <= 1'b0;
         term_s2_q <= 1'b0;
         cke_prev_q <= 1'b0;
      end else begin
         pins_s1_q <= pins_raw;
         pins_s2_q <= pins_s1_q;
         bank_s1_q <= bank_addr;
         bank_s2_q <= bank_s1_q;
         addr_s1_q <= addr;
         addr_s2_q <= addr_s1_q;
         term_s1_q <= termination_control;
         term_s2_q <= term_s1_q;
         cke_prev_q <= pins_s2_q.clock_enable;
      end
   end

   // Termination input not routed here
   cmd_pin_decode u_decode (
      .pins(pins_s2_q),
      .cke_prev(cke_prev_q),
      .cmd(cmd)
   );

   wire is_load = (cmd == CMD_MODE_LOAD);
   wire load_one = is_load && (bank_s2_q == `SEL_EXT_ONE);
   wire load_two = is_load && (bank_s2_q == `SEL_EXT_TWO);
   wire load_three = is_load && (bank_s2_q == `SEL_EXT_THREE);
   wire self_enter = (cmd == CMD_SELF_ENTER) && !self_q;
   wire self_exit = self_q && pins_s2_q.clock_enable;
   wire loop_on_reg = bit_of(ext_one_q, `LOOP_ENABLE_POS);
   wire loop_reenable = load_one && bit_of(addr_s2_q, `LOOP_ENABLE_POS) && !loop_on_reg;
   wire [2:0] lat_field = addr_s2_q[`LATENCY_HI_POS:`LATENCY_LO_POS];
   wire [2:0] lat_cur = ext_one_q[`LATENCY_HI_POS:`LATENCY_LO_POS];
   wire [2:0] lat_eff = (lat_cur > `LATENCY_MAX) ? `LATENCY_MAX : lat_cur;
   wire [1:0] term_pair = {bit_of(ext_one_q, `TERM_HIGH_POS), bit_of(ext_one_q, `TERM_LOW_POS)};
   wire outs_off = bit_of(ext_one_q, `OUTPUT_DISABLE_POS);
   wire comp_off = bit_of(ext_one_q, `STROBE_COMP_DIS_POS);
   wire rd_strobe = bit_of(ext_one_q, `READ_STROBE_EN_POS);
   wire is_col = (cmd == CMD_READ) || (cmd == CMD_WRITE);

   // Mode registers hold until reloaded
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_one_q <= `EXT_RESET;
         ext_two_q <= `EXT_RESET;
         ext_three_q <= `EXT_RESET;
      end else begin
         if (load_one) ext_one_q <= {addr_s2_q[12:6], lat_field, addr_s2_q[2:0]};
         if (load_two) ext_two_q <= addr_s2_q;
         if (load_three) ext_three_q <= addr_s2_q;
      end
   end

   // Self refresh and power-down states
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         self_q <= 1'b0;
         pdown_q <= 1'b0;
      end else begin
         if (self_enter) self_q <= 1'b1;
         else if (self_exit) self_q <= 1'b0;
         if (cmd == CMD_PDOWN_ENTER) pdown_q <= 1'b1;
         else if (cmd == CMD_PDOWN_EXIT) pdown_q <= 1'b0;
      end
   end

   // Loop reset pulse and lock count
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_pulse_q <= 1'b0;
         lock_cnt_q <= '0;
      end else begin
         reset_pulse_q <= self_exit || loop_reenable;
         if (self_q || !loop_on_reg || reset_pulse_q) lock_cnt_q <= '0;
         else if (lock_cnt_q != 8'(`LOOP_LOCK_CYCLES)) lock_cnt_q <= lock_cnt_q + 8'h01;
      end
   end

   assign col_in = '{is_col, cmd == CMD_WRITE, bit_of(addr_s2_q, `AUTO_PRE_POS),
                     bank_s2_q, addr_s2_q};

   posted_delay u_delay (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .cmd_in(col_in),
      .latency(lat_eff),
      .cmd_out(col_out)
   );

   // Registered outputs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         loop_enable <= 1'b0;
         loop_reset <= 1'b0;
         loop_locked <= 1'b0;
         drive_reduced <= 1'b0;
         strobe_oe <= 1'b0;
         strobe_complement_oe <= 1'b0;
         read_strobe_oe <= 1'b0;
         read_strobe_complement_oe <= 1'b0;
         data_oe_allow <= 1'b0;
         termination_resistance <= TERM_OFF;
         termination_on <= 1'b0;
         posted_latency <= 3'h0;
         read_latency <= 4'h0;
         write_latency <= 4'h0;
         last_cmd <= CMD_NONE;
         self_refresh <= 1'b0;
         power_down <= 1'b0;
         precharge_issue <= 1'b0;
         precharge_all <= 1'b0;
         precharge_bank <= '0;
         activate_issue <= 1'b0;
         column_issue <= '0;
         ext_two_value <= '0;
      end else begin
         loop_enable <= loop_on_reg && !self_q;
         loop_reset <= reset_pulse_q;
         loop_locked <= lock_cnt_q == 8'(`LOOP_LOCK_CYCLES);
         drive_reduced <= bit_of(ext_one_q, `DRIVE_STRENGTH_POS);
         strobe_oe <= !outs_off;
         strobe_complement_oe <= !outs_off && !comp_off;
         read_strobe_oe <= !outs_off && rd_strobe;
         read_strobe_complement_oe <= !outs_off && rd_strobe && !comp_off;
         data_oe_allow <= !outs_off;
         termination_resistance <= term_sel_t'(term_pair);
         termination_on <= (term_pair != 2'h0) && !self_q && term_s2_q;
         posted_latency <= lat_eff;
         read_latency <= {1'b0, lat_eff} + {1'b0, column_latency};
         write_latency <= {1'b0, lat_eff} + {1'b0, column_latency} - 4'h1;
         if (cmd != CMD_NONE) last_cmd <= cmd;
         self_refresh <= self_q;
         power_down <= pdown_q;
         precharge_issue <= cmd == CMD_PRECHARGE;
         precharge_all <= bit_of(addr_s2_q, `AUTO_PRE_POS);
         precharge_bank <= bank_s2_q;
         activate_issue <= cmd == CMD_ACTIVATE;
         column_issue <= col_out;
         ext_two_value <= ext_two_q;
      end
   end
endmodule

// file: ext_mode_cfg.svh
// Purpose: offsets, field positions, reset values and counts of the extended mode logic
// Assumes: 13-bit operation code, 3-bit bank select
// Notes: definitions only
`ifndef EXT_MODE_CFG_SVH
`define EXT_MODE_CFG_SVH
`define ADDR_W 13
`define BANK_W 3
`define SEL_BASE 3'h0
`define SEL_EXT_ONE 3'h1
`define SEL_EXT_TWO 3'h2
`define SEL_EXT_THREE 3'h3
`define LOOP_ENABLE_POS 0
`define DRIVE_STRENGTH_POS 1
`define TERM_LOW_POS 2
`define LATENCY_LO_POS 3
`define LATENCY_HI_POS 5
`define TERM_HIGH_POS 6
`define STROBE_COMP_DIS_POS 10
`define READ_STROBE_EN_POS 11
`define OUTPUT_DISABLE_POS 12
`define AUTO_PRE_POS 10
`define EXT_RESET 13'h0000
`define LATENCY_MAX 3'h6
`define COL_LATENCY_DEFAULT 3'h3
`define LOOP_LOCK_CYCLES 200
`define TERM_HOLD_CYCLES 8
`endif

// file: ext_mode_pkg.sv
// Purpose: types shared by the extended mode decoder files
// Assumes: widths from the config header
// Notes: none
package ext_mode_pkg;
   typedef enum logic [3:0] {
      CMD_NONE, CMD_DESELECT, CMD_NOP, CMD_MODE_LOAD, CMD_REFRESH, CMD_SELF_ENTER,
      CMD_SELF_EXIT, CMD_PRECHARGE, CMD_ACTIVATE, CMD_WRITE, CMD_READ,
      CMD_PDOWN_ENTER, CMD_PDOWN_EXIT
   } cmd_t;
   typedef enum logic [1:0] {TERM_OFF, TERM_75, TERM_150, TERM_50} term_sel_t;
   typedef struct packed {
      logic chip_select_n;
      logic row_strobe_n;
      logic col_strobe_n;
      logic write_enable_n;
      logic clock_enable;
   } cmd_pins_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic auto_precharge;
      logic [2:0] bank;
      logic [12:0] addr;
   } col_cmd_t;
endpackage

// file: cmd_pin_decode.sv
// Purpose: decode one command from sampled control pins
// Assumes: pins already synchronised; previous clock enable supplied by caller
// Notes: combinational
`timescale 1ns/1ns
module cmd_pin_decode
   import ext_mode_pkg::*;
(
   // Pins
   input wire cmd_pins_t pins,
   input wire logic cke_prev,
   // Result
   output cmd_t cmd
);
   wire [2:0] rcw = {pins.row_strobe_n, pins.col_strobe_n, pins.write_enable_n};
   wire cs = ~pins.chip_select_n;
   wire idle_code = ~cs | (rcw == 3'h7);

   always_comb begin
      cmd = CMD_NONE;
      if (cke_prev && !pins.clock_enable) begin
         if (cs && rcw == 3'h1) cmd = CMD_SELF_ENTER;
         else if (idle_code) cmd = CMD_PDOWN_ENTER;
      end else if (!cke_prev && pins.clock_enable) begin
         if (idle_code) cmd = CMD_PDOWN_EXIT;
      end else if (cke_prev && pins.clock_enable) begin
         if (!cs) cmd = CMD_DESELECT;
         else begin
            case (rcw)
               3'h0: cmd = CMD_MODE_LOAD;
               3'h1: cmd = CMD_REFRESH;
               3'h2: cmd = CMD_PRECHARGE;
               3'h3: cmd = CMD_ACTIVATE;
               3'h4: cmd = CMD_WRITE;
               3'h5: cmd = CMD_READ;
               3'h7: cmd = CMD_NOP;
               default: cmd = CMD_NONE;
            endcase
         end
      end
   end
endmodule

// file: posted_delay.sv
// Purpose: hold a column command for the posted latency
// Assumes: latency 0 to 6
// Notes: shift line of flip-flops, tap selected by index
`timescale 1ns/1ns
module posted_delay
   import ext_mode_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Command
   input wire col_cmd_t cmd_in,
   input wire logic [2:0] latency,
   output col_cmd_t cmd_out
);
   col_cmd_t line_q [1:6];

   genvar i;
   generate
      for (i = 1; i <= 6; i++) begin : g_stage
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) line_q[i] <= '0;
            else line_q[i] <= (i == 1) ? cmd_in : line_q[(i == 1) ? 1 : i - 1];
         end
      end
   endgenerate

   assign cmd_out = (latency == 3'h0) ? cmd_in : line_q[latency];
endmodule

// file: ext_mode_decode_chk.sv
// Purpose: port checks of the extended mode decoder
// Assumes: one clock, async active-low reset
// Notes: bound from the bench top
`timescale 1ns/1ns
module ext_mode_decode_chk
   import ext_mode_pkg::*;
(
   // Clock, reset and latency input
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [2:0] column_latency,
   // Loop and output controls
   input wire logic loop_enable,
   input wire logic loop_reset,
   input wire logic loop_locked,
   input wire logic strobe_oe,
   input wire logic strobe_complement_oe,
   input wire logic read_strobe_oe,
   input wire logic read_strobe_complement_oe,
   input wire logic data_oe_allow,
   // Termination and latencies
   input wire term_sel_t termination_resistance,
   input wire logic termination_on,
   input wire logic [2:0] posted_latency,
   input wire logic [3:0] read_latency,
   input wire logic [3:0] write_latency,
   // Command stream
   input wire logic self_refresh,
   input wire logic precharge_issue,
   input wire logic precharge_all,
   input wire col_cmd_t column_issue
);
   logic [1:0] up_q;
   // Latency outputs settle a few edges after reset
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_rl_sum;
      up_q == 2'h3 |-> read_latency == {1'b0, posted_latency} + {1'b0, $past(column_latency)};
   endproperty
   a_rl_sum: assert property (p_rl_sum) else $error("read latency not sum");
   property p_wl_less;
      up_q == 2'h3 |-> write_latency == read_latency - 4'h1;
   endproperty
   a_wl_less: assert property (p_wl_less) else $error("write latency wrong");
   property p_read_strobe_complement_comp;
      read_strobe_complement_oe |-> read_strobe_oe && strobe_complement_oe;
   endproperty
   a_read_strobe_complement_comp: assert property (p_read_strobe_complement_comp) else $error("complement enable");
   property p_out_dis;
      !data_oe_allow |-> !(strobe_oe || strobe_complement_oe || read_strobe_oe);
   endproperty
   a_out_dis: assert property (p_out_dis) else $error("outputs not off");
   property p_term_on;
      termination_on |-> termination_resistance != TERM_OFF && !self_refresh;
   endproperty
   a_term_on: assert property (p_term_on) else $error("termination on wrongly");
   property p_al_max;
      posted_latency <= 3'h6;
   endproperty
   a_al_max: assert property (p_al_max) else $error("posted latency above 6");
   property p_reset_pulse;
      loop_reset |=> !loop_reset;
   endproperty
   a_reset_pulse: assert property (p_reset_pulse) else $error("loop reset long");
   property p_lock_wait;
      loop_reset |=> !loop_locked [*8];
   endproperty
   a_lock_wait: assert property (p_lock_wait) else $error("locked too soon");
   property p_self_off;
      $rose(self_refresh) |-> ##[0:2] !loop_enable;
   endproperty
   a_self_off: assert property (p_self_off) else $error("loop on in self refresh");
   c_reset: cover property (loop_reset);
   c_col: cover property (column_issue.valid);
   c_self: cover property (self_refresh);
   c_pre_all: cover property (precharge_issue && precharge_all);
endmodule

// file: mem_ctl_model.sv
// Purpose: memory controller driving the command pins
// Assumes: caller spaces loads and waits for lock
// Notes: idle address shows inverse of last value
`timescale 1ns/1ns
module mem_ctl_model
   import ext_mode_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Command bus
   output cmd_pins_t pins,
   output logic [2:0] bank_addr,
   output logic [12:0] addr
);
   initial begin
      pins = 5'h1F;
      bank_addr = 3'h0;
      addr = 13'h0000;
   end
   // One command for one clock, then no-operation
   task automatic send(input logic [3:0] crwe, input logic cke, input logic [2:0] ba,
         input logic [12:0] a);
      @(posedge sys_clk);
      pins <= {crwe, cke};
      bank_addr <= ba;
      addr <= a;
      @(posedge sys_clk);
      pins <= {4'h7, cke};
      bank_addr <= ~ba;
      addr <= ~a;
   endtask
endmodule

// file: ext_mode_decode_tb_top.sv
// Purpose: self-checking bench of the extended mode decoder
// Assumes: controller model drives the pins
// Notes: column latency swept by the field scenario
`timescale 1ns/1ns
module ext_mode_decode_tb_top
   import ext_mode_pkg::*;
;
   localparam logic [3:0] LM = 4'h0, REF = 4'h1, PRE = 4'h2, ACT = 4'h3;
   localparam logic [3:0] WR = 4'h4, RD = 4'h5, NOP = 4'h7;
   logic sys_clk = 1'b0, rst_n = 1'b0, termination_control = 1'b0;
   logic [2:0] column_latency = 3'h3;
   cmd_pins_t pins;
   logic [2:0] bank_addr, posted_latency, precharge_bank;
   logic [12:0] addr, ext_two_value;
   logic loop_enable, loop_reset, loop_locked, drive_reduced, strobe_oe;
   logic strobe_complement_oe, read_strobe_oe, read_strobe_complement_oe, data_oe_allow;
   logic termination_on, self_refresh, power_down, precharge_issue, precharge_all;
   logic activate_issue;
   term_sel_t termination_resistance;
   logic [3:0] read_latency, write_latency;
   cmd_t last_cmd;
   col_cmd_t column_issue;
   int mismatches = 0, samples_checked = 0;
   always #10 sys_clk = ~sys_clk;
   mem_ctl_model ctl_u (.sys_clk, .pins, .bank_addr, .addr);
   ext_mode_decode dut_u (.sys_clk, .rst_n, .chip_select_n(pins.chip_select_n),
      .row_strobe_n(pins.row_strobe_n), .col_strobe_n(pins.col_strobe_n),
      .write_enable_n(pins.write_enable_n), .clock_enable(pins.clock_enable), .bank_addr,
      .addr, .termination_control, .column_latency, .loop_enable, .loop_reset, .loop_locked,
      .drive_reduced, .strobe_oe, .strobe_complement_oe, .read_strobe_oe,
      .read_strobe_complement_oe, .data_oe_allow, .termination_resistance, .termination_on,
      .posted_latency, .read_latency, .write_latency, .last_cmd, .self_refresh, .power_down,
      .precharge_issue, .precharge_all, .precharge_bank, .activate_issue, .column_issue,
      .ext_two_value);
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [22:0] exp, input logic [22:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   // Bounded wait for one output to go high
   task automatic wait_on(input int sel, output int n);
      logic hit;
      n = 0;
      hit = 1'b0;
      while (hit !== 1'b1 && n < 400) begin
         idle(1);
         n++;
         case (sel)
            0: hit = precharge_issue;
            1: hit = activate_issue;
            2: hit = column_issue.valid;
            3: hit = loop_locked;
            4: hit = self_refresh;
            default: hit = power_down;
         endcase
      end
      if (hit !== 1'b1) begin
         mismatches++;
         $display("ERROR wait %0d expected 1 seen %0b", sel, hit);
         close_out();
      end
   endtask
   task automatic s_loop();
      int n;
      ctl_u.send(LM, 1'b1, 3'h1, 13'h0000);
      idle(6);
      cmp("loop off", 23'h0, {22'h0, loop_enable});
      ctl_u.send(REF, 1'b1, 3'h0, 13'h0000);
      idle(2);
      cmp("refresh", 23'(CMD_REFRESH), 23'(last_cmd));
      ctl_u.send(PRE, 1'b1, 3'h0, 13'h0400);
      wait_on(0, n);
      cmp("pre after ref", 23'h1, {22'h0, precharge_all});
      ctl_u.send(LM, 1'b1, 3'h1, 13'h0001);
      wait_on(3, n);
      cmp("loop on", 23'h1, {22'h0, loop_enable});
      cmp("lock wait", 23'h1, {22'h0, n >= 196});
   endtask
   task automatic s_fields();
      logic [12:0] m [8] = '{13'h0003, 13'h0005, 13'h0041, 13'h0045, 13'h0801,
         13'h0C01, 13'h1801, 13'h0401};
      logic [12:0] v;
      logic [2:0] al;
      for (int i = 0; i < 8; i++) begin
         v = m[i] | 13'(i << 3);
         al = (i == 7) ? 3'h6 : 3'(i);
         column_latency <= 3'(3 + i % 5);
         ctl_u.send(LM, 1'b1, 3'h1, v);
         idle(6);
         cmp("controls", {v[1], !v[12], !v[10] && !v[12], v[11] && !v[12],
            v[11] && !v[10] && !v[12], !v[12], v[6], v[2]}, {drive_reduced, strobe_oe,
            strobe_complement_oe, read_strobe_oe, read_strobe_complement_oe, data_oe_allow,
            termination_resistance});
         cmp("latency", {al, {1'b0, al} + {1'b0, column_latency},
            {1'b0, al} + {1'b0, column_latency} - 4'h1},
            {posted_latency, read_latency, write_latency});
      end
   endtask
   task automatic s_regs();
      logic [2:0] ba [4] = '{3'h0, 3'h3, 3'h4, 3'h7};
      ctl_u.send(LM, 1'b1, 3'h2, 13'h1ABC);
      idle(6);
      cmp("ext two", 23'h1ABC, {10'h0, ext_two_value});
      for (int i = 0; i < 4; i++) begin
         ctl_u.send(LM, 1'b1, ba[i], 13'h0000);
         idle(6);
         cmp("kept", {3'h6, 13'h1ABC}, {posted_latency, ext_two_value});
      end
   endtask
   task automatic s_cmds();
      int n0, n1;
      ctl_u.send(LM, 1'b1, 3'h1, 13'h0005);
      idle(9);
      termination_control <= 1'b1;
      ctl_u.send(PRE, 1'b1, 3'h5, 13'h0400);
      wait_on(0, n0);
      cmp("pre all", 23'h1, {22'h0, precharge_all});
      ctl_u.send(PRE, 1'b1, 3'h5, 13'h0000);
      wait_on(0, n0);
      cmp("pre one", 23'h5, {19'h0, precharge_all, precharge_bank});
      ctl_u.send(ACT, 1'b1, 3'h1, 13'h0123);
      wait_on(1, n0);
      cmp("last cmd", 23'(CMD_ACTIVATE), 23'(last_cmd));
      ctl_u.send(RD, 1'b1, 3'h2, 13'h0413);
      wait_on(2, n0);
      cmp("read", {3'h5, 3'h2, 13'h0413}, column_issue[18:0]);
      cmp("term on", 23'h1, {22'h0, termination_on});
      ctl_u.send(LM, 1'b1, 3'h1, 13'h0025);
      idle(6);
      ctl_u.send(WR, 1'b1, 3'h6, 13'h0012);
      wait_on(2, n1);
      cmp("write", {3'h6, 3'h6, 13'h0012}, column_issue[18:0]);
      cmp("posted hold", 23'h4, 23'(n1 - n0));
   endtask
   task automatic s_self();
      int n;
      termination_control <= 1'b0;
      ctl_u.send(REF, 1'b0, 3'h0, 13'h0000);
      wait_on(4, n);
      idle(3);
      cmp("self off", 23'h0, {21'h0, loop_enable, termination_on});
      ctl_u.send(NOP, 1'b1, 3'h0, 13'h0000);
      idle(6);
      cmp("self exit", 23'h2, {20'h0, self_refresh, loop_enable, loop_locked});
      wait_on(3, n);
      ctl_u.send(NOP, 1'b0, 3'h0, 13'h0000);
      wait_on(5, n);
      ctl_u.send(NOP, 1'b1, 3'h0, 13'h0000);
      idle(6);
      cmp("pdown exit", 23'h0, {22'h0, power_down});
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      idle(4);
      s_loop();
      s_fields();
      s_regs();
      s_cmds();
      s_self();
      close_out();
   end
endmodule
bind ext_mode_decode ext_mode_decode_chk chk_u (.sys_clk, .rst_n, .column_latency,
   .loop_enable, .loop_reset, .loop_locked, .strobe_oe, .strobe_complement_oe,
   .read_strobe_oe, .read_strobe_complement_oe, .data_oe_allow, .termination_resistance,
   .termination_on, .posted_latency, .read_latency, .write_latency, .self_refresh,
   .precharge_issue, .precharge_all, .column_issue);
